// *** verilog/adcr_pkg.sv ***
// Constants and types of the converter configuration register bank.
// Assumes one clock domain and a decoded register write/read port.
package adcr_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int NUM_DATA_CH = 8;
    localparam int SAMPLE_W = 14;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [8:0] CHANNEL_SELECT_LOW = 9'h004;
    localparam logic [8:0] CHANNEL_SELECT_HIGH = 9'h005;
    localparam logic [8:0] POWER_MODE_CONTROL = 9'h008;
    localparam logic [8:0] ENHANCEMENT_CONTROL = 9'h00c;
    localparam logic [8:0] OUTPUT_MODE_CONTROL = 9'h014;
    localparam logic [8:0] OUTPUT_ADJUST_CONTROL = 9'h015;
    localparam logic [8:0] CLOCK_PHASE_CONTROL = 9'h016;
    localparam logic [8:0] UPDATE_STROBE = 9'h0ff;
    localparam logic [8:0] RATE_OVERRIDE = 9'h100;

    // ----------------------------------------
    // Writable bit masks
    // ----------------------------------------
    localparam logic [7:0] SEL_LOW_MASK = 8'h0f;
    localparam logic [7:0] SEL_HIGH_MASK = 8'h3f;
    localparam logic [7:0] POWER_MASK = 8'h23;
    localparam logic [7:0] ENH_MASK = 8'h04;
    localparam logic [7:0] OUT_MODE_MASK = 8'h45;
    localparam logic [7:0] OUT_ADJ_MASK = 8'h31;
    localparam logic [7:0] PHASE_MASK = 8'h7f;
    localparam logic [7:0] OVERRIDE_MASK = 8'h77;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SEL_FRAME_BIT = 4;
    localparam int SEL_BITCLK_BIT = 5;
    localparam int PIN_STANDBY_BIT = 5;
    localparam int CHOP_BIT = 2;
    localparam int REDUCED_SWING_BIT = 6;
    localparam int INVERT_BIT = 2;
    localparam int TWOS_COMP_BIT = 0;
    localparam int TERM_LSB = 4;
    localparam int DRIVE2X_BIT = 0;
    localparam int IN_PHASE_LSB = 4;
    localparam int TRANSFER_BIT = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] SEL_LOW_RESET = 8'h0f;
    localparam logic [7:0] SEL_HIGH_RESET = 8'h3f;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [7:0] ENH_RESET = 8'h00;
    localparam logic [7:0] OUT_MODE_RESET = 8'h01;
    localparam logic [7:0] OUT_ADJ_RESET = 8'h00;
    localparam logic [7:0] PHASE_RESET = 8'h03;
    localparam logic [7:0] OVERRIDE_RESET = 8'h00;

    localparam logic [9:0] DEG_PER_STEP = 10'h03c;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCR_PM_NORMAL = 2'b00,
        ADCR_PM_POWER_DOWN = 2'b01,
        ADCR_PM_STANDBY = 2'b10,
        ADCR_PM_DIGITAL_RESET = 2'b11
    } adcr_pmode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] data;
    } adcr_req_t;

    typedef struct packed {
        logic clockEnable;
        logic datapathReset;
        logic outputEnable;
    } adcr_power_t;

    typedef struct packed {
        logic invert;
        logic twosComp;
        logic [1:0] term;
        logic drive2x;
    } adcr_chan_t;

    typedef struct packed {
        logic [1:0] term;
        logic drive2x;
    } adcr_clkch_t;

endpackage

// *** verilog/adcr_phase_delay.sv ***
// Sampling strobe generator for the divided input clock.
// Assumes divider ratio and enable come from logic on the same clock.
module adcr_phase_delay (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Divider setting
    input wire logic divActive,
    input wire logic [2:0] divRatio,
    input wire logic [2:0] phase,
    // Strobe
    output logic sampleStrobe
);
    import adcr_pkg::*;

    logic [2:0] cycleCount;
    logic [2:0] phaseUsed;

    // Illegal phase above ratio is clamped so a strobe still appears
    assign phaseUsed = (phase > divRatio) ? divRatio : phase;

    always_ff @(posedge clk) begin
        if (rst || !divActive || cycleCount >= divRatio) begin
            cycleCount <= 3'h0;
        end else begin
            cycleCount <= cycleCount + 3'h1;
        end
    end

    // Undivided clock samples every cycle, phase ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            sampleStrobe <= 1'b0;
        end else if (!divActive) begin
            sampleStrobe <= 1'b1;
        end else begin
            sampleStrobe <= (cycleCount == phaseUsed);
        end
    end

endmodule

// *** verilog/adcr_config_regs.sv ***
// Configuration register bank of an eight channel converter.
// Assumes a decoded register port on clk and an asynchronous
// power-down pin; rst is the power-on reset only.
module adcr_config_regs (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire adcr_pkg::adcr_req_t regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Pins and divider state
    input wire logic power_down_pin,
    input wire logic clkDivActive,
    input wire logic [2:0] clkDivRatio,
    // Sample path
    input wire logic [adcr_pkg::NUM_DATA_CH*adcr_pkg::SAMPLE_W-1:0] sampleIn,
    output logic [adcr_pkg::NUM_DATA_CH*adcr_pkg::SAMPLE_W-1:0] sampleOut,
    output logic sampleStrobe,
    // Power and global controls
    output adcr_pkg::adcr_power_t powerCtl,
    output logic chopEnable,
    output logic reducedSwing,
    // Per channel controls
    output adcr_pkg::adcr_chan_t [adcr_pkg::NUM_DATA_CH-1:0] dataChanCfg,
    output adcr_pkg::adcr_clkch_t frameClockCfg,
    output adcr_pkg::adcr_clkch_t bitClockCfg,
    // Bit clock phase
    output logic [3:0] bitClockPhase,
    output logic [9:0] bitClockPhaseDeg,
    // Applied override
    output logic [7:0] rateOverride
);
    import adcr_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] selLow;
    logic [7:0] selHigh;
    logic [7:0] powerReg;
    logic [7:0] enhReg;
    logic [7:0] phaseReg;
    logic [7:0] overrideStage;
    logic [7:0] outMode [NUM_DATA_CH];
    logic [7:0] outAdj [NUM_DATA_CH];
    logic [7:0] frameAdj;
    logic [7:0] bitClkAdj;
    logic pinMeta;
    logic pinSync;
    logic [NUM_DATA_CH-1:0] dataSel;
    logic wrHit;
    adcr_pmode_t effMode;
    adcr_pmode_t next_mode;
    logic [7:0] next_rd;
    logic localStrobe;

    function automatic logic [7:0] masked(input logic [7:0] v,
                                          input logic [7:0] m);
        masked = v & m;
    endfunction

    function automatic logic [9:0] phase_degrees(input logic [3:0] c);
        phase_degrees = 10'({6'h00, c} * DEG_PER_STEP);
    endfunction

    // ----------------------------------------
    // Channel selection
    // ----------------------------------------
    assign dataSel = {selHigh[3:0], selLow[3:0]};
    assign wrHit = regReq.wr;

    // ----------------------------------------
    // Global registers, effective on write except the override, which is only staged here
    // ----------------------------------------
    // Only the power-on reset clears these; no power mode touches them
    always_ff @(posedge clk) begin
        if (rst) begin
            selLow <= SEL_LOW_RESET;
            selHigh <= SEL_HIGH_RESET;
            powerReg <= POWER_RESET;
            enhReg <= ENH_RESET;
            phaseReg <= PHASE_RESET;
            overrideStage <= OVERRIDE_RESET;
        end else if (wrHit) begin
            unique case (regReq.addr)
                CHANNEL_SELECT_LOW:
                    selLow <= masked(regReq.data, SEL_LOW_MASK);
                CHANNEL_SELECT_HIGH:
                    selHigh <= masked(regReq.data, SEL_HIGH_MASK);
                POWER_MODE_CONTROL:
                    powerReg <= masked(regReq.data, POWER_MASK);
                ENHANCEMENT_CONTROL:
                    enhReg <= masked(regReq.data, ENH_MASK);
                CLOCK_PHASE_CONTROL:
                    phaseReg <= masked(regReq.data, PHASE_MASK);
                RATE_OVERRIDE:
                    overrideStage <= masked(regReq.data, OVERRIDE_MASK);
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Override transfer
    // ----------------------------------------
    // Staged value only goes live on the transfer bit
    always_ff @(posedge clk) begin
        if (rst) begin
            rateOverride <= OVERRIDE_RESET;
        end else if (wrHit && regReq.addr == UPDATE_STROBE
                     && regReq.data[TRANSFER_BIT]) begin
            rateOverride <= overrideStage;
        end
    end

    // ----------------------------------------
    // Per channel registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_DATA_CH; i++) begin
                outMode[i] <= OUT_MODE_RESET;
                outAdj[i] <= OUT_ADJ_RESET;
            end
        end else if (wrHit) begin
            for (int i = 0; i < NUM_DATA_CH; i++) begin
                if (dataSel[i] && regReq.addr == OUTPUT_MODE_CONTROL) begin
                    outMode[i] <= masked(regReq.data, OUT_MODE_MASK);
                end
                if (dataSel[i] && regReq.addr == OUTPUT_ADJUST_CONTROL) begin
                    outAdj[i] <= masked(regReq.data, OUT_ADJ_MASK);
                end
            end
        end
    end

    // Clock channels only take the output adjust register
    always_ff @(posedge clk) begin
        if (rst) begin
            frameAdj <= OUT_ADJ_RESET;
            bitClkAdj <= OUT_ADJ_RESET;
        end else if (wrHit && regReq.addr == OUTPUT_ADJUST_CONTROL) begin
            if (selHigh[SEL_FRAME_BIT]) begin
                frameAdj <= masked(regReq.data, OUT_ADJ_MASK);
            end
            if (selHigh[SEL_BITCLK_BIT]) begin
                bitClkAdj <= masked(regReq.data, OUT_ADJ_MASK);
            end
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    // Local registers read from the lowest selected channel
    always_comb begin
        next_rd = 8'h00;
        unique case (regReq.addr)
            CHANNEL_SELECT_LOW: next_rd = selLow;
            CHANNEL_SELECT_HIGH: next_rd = selHigh;
            POWER_MODE_CONTROL: next_rd = powerReg;
            ENHANCEMENT_CONTROL: next_rd = enhReg;
            CLOCK_PHASE_CONTROL: next_rd = phaseReg;
            RATE_OVERRIDE: next_rd = overrideStage;
            OUTPUT_MODE_CONTROL: begin
                for (int i = NUM_DATA_CH - 1; i >= 0; i--) begin
                    if (dataSel[i]) begin
                        next_rd = outMode[i];
                    end
                end
            end
            OUTPUT_ADJUST_CONTROL: begin
                if (selHigh[SEL_BITCLK_BIT]) begin
                    next_rd = bitClkAdj;
                end
                if (selHigh[SEL_FRAME_BIT]) begin
                    next_rd = frameAdj;
                end
                for (int i = NUM_DATA_CH - 1; i >= 0; i--) begin
                    if (dataSel[i]) begin
                        next_rd = outAdj[i];
                    end
                end
            end
            // Transfer bit self clears and unmapped reads give zero
            default: next_rd = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdData <= regReq.rd ? next_rd : 8'h00;
            regRdValid <= regReq.rd;
        end
    end

    // ----------------------------------------
    // Power modes
    // ----------------------------------------
    // Pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            pinMeta <= power_down_pin;
            pinSync <= pinMeta;
        end
    end

    // Internal field overrides the pin unless it is normal
    always_comb begin
        next_mode = adcr_pmode_t'(powerReg[1:0]);
        if (next_mode == ADCR_PM_NORMAL && pinSync) begin
            next_mode = powerReg[PIN_STANDBY_BIT] ? ADCR_PM_STANDBY
                                                  : ADCR_PM_POWER_DOWN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            effMode <= ADCR_PM_NORMAL;
        end else begin
            effMode <= next_mode;
        end
    end

    // Clock stays on in digital reset so the reset can propagate
    always_ff @(posedge clk) begin
        if (rst) begin
            powerCtl <= '{clockEnable: 1'b1, datapathReset: 1'b0,
                          outputEnable: 1'b1};
        end else begin
            unique case (effMode)
                ADCR_PM_NORMAL:
                    powerCtl <= '{1'b1, 1'b0, 1'b1};
                ADCR_PM_POWER_DOWN:
                    powerCtl <= '{1'b0, 1'b1, 1'b0};
                ADCR_PM_STANDBY:
                    powerCtl <= '{1'b0, 1'b0, 1'b0};
                ADCR_PM_DIGITAL_RESET:
                    powerCtl <= '{1'b1, 1'b1, 1'b0};
            endcase
        end
    end

    // ----------------------------------------
    // Global and per channel control outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            chopEnable <= 1'b0;
            reducedSwing <= 1'b0;
            bitClockPhase <= PHASE_RESET[3:0];
            bitClockPhaseDeg <= phase_degrees(PHASE_RESET[3:0]);
        end else begin
            chopEnable <= enhReg[CHOP_BIT];
            reducedSwing <= outMode[0][REDUCED_SWING_BIT];
            bitClockPhase <= phaseReg[3:0];
            bitClockPhaseDeg <= phase_degrees(phaseReg[3:0]);
        end
    end

    // Double drive only counts on the clock channels with no termination selected; data channels never drive double
    always_ff @(posedge clk) begin
        if (rst) begin
            dataChanCfg <= '0;
            frameClockCfg <= '0;
            bitClockCfg <= '0;
        end else begin
            for (int i = 0; i < NUM_DATA_CH; i++) begin
                dataChanCfg[i] <= '{
                    invert: outMode[i][INVERT_BIT],
                    twosComp: outMode[i][TWOS_COMP_BIT],
                    term: outAdj[i][TERM_LSB+:2],
                    drive2x: 1'b0};
            end
            frameClockCfg <= '{frameAdj[TERM_LSB+:2],
                               frameAdj[DRIVE2X_BIT]
                               && frameAdj[TERM_LSB+:2] == 2'b00};
            bitClockCfg <= '{bitClkAdj[TERM_LSB+:2],
                             bitClkAdj[DRIVE2X_BIT]
                             && bitClkAdj[TERM_LSB+:2] == 2'b00};
        end
    end

    // ----------------------------------------
    // Sampling phase and output stream
    // ----------------------------------------
    adcr_phase_delay i_adcr_phase_delay (
        .clk(clk),
        .rst(rst),
        .divActive(clkDivActive),
        .divRatio(clkDivRatio),
        .phase(phaseReg[IN_PHASE_LSB+:3]),
        .sampleStrobe(localStrobe)
    );

    // Offset binary is twos complement with the sign bit flipped
    always_ff @(posedge clk) begin
        if (rst || powerCtl.datapathReset) begin
            sampleOut <= '0;
            sampleStrobe <= 1'b0;
        end else if (powerCtl.clockEnable) begin
            sampleStrobe <= localStrobe && powerCtl.outputEnable;
            for (int i = 0; i < NUM_DATA_CH; i++) begin
                if (!powerCtl.outputEnable) begin
                    sampleOut[i*SAMPLE_W+:SAMPLE_W] <= '0;
                end else if (localStrobe) begin
                    sampleOut[i*SAMPLE_W+:SAMPLE_W] <=
                        (sampleIn[i*SAMPLE_W+:SAMPLE_W]
                         ^ {!dataChanCfg[i].twosComp,
                            {(SAMPLE_W-1){1'b0}}})
                        ^ {SAMPLE_W{dataChanCfg[i].invert}};
                end
            end
        end else begin
            sampleStrobe <= 1'b0;
        end
    end

endmodule

// *** dv/adcr_host.sv ***
// Host model that drives the register port of the configuration bank.
// Assumes the bench calls its tasks; requests change at the falling edge.
module adcr_host (
    // Clock
    input wire logic clk,
    // Register port
    output adcr_pkg::adcr_req_t regReq,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // Divider ratio known to the host
    input wire logic [2:0] divRatio
);
    timeunit 1ns;
    timeprecision 1ps;
    import adcr_pkg::*;

    initial regReq = '0;

    // One-cycle write pulse, then idle
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == CLOCK_PHASE_CONTROL && v[6:4] > divRatio) begin
            v[6:4] = divRatio;
        end
        @(negedge clk);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
        @(negedge clk);
        regReq = '0;
    endtask

    // Bounded wait for the read answer
    task automatic rd(input logic [8:0] a, output logic [7:0] d,
                      output logic ok);
        @(negedge clk);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge clk);
        regReq = '0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && ok == 1'b0; i++) begin
            if (regRdValid === 1'b1) begin
                ok = 1'b1;
                d = regRdData;
            end else begin
                @(negedge clk);
            end
        end
    endtask

    // Digital reset after an unstable clock, then normal mode
    task automatic digitalReset();
        wr(POWER_MODE_CONTROL, 8'h03);
        wr(POWER_MODE_CONTROL, 8'h00);
    endtask
endmodule

// *** dv/adcr_config_regs_chk.sv ***
// Port assertions of the configuration register bank.
// Assumes one clock domain and the synchronous power-on reset.
module adcr_config_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire adcr_pkg::adcr_req_t regReq,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // Divider and controls
    input wire logic clkDivActive,
    input wire logic [2:0] clkDivRatio,
    input wire logic sampleStrobe,
    input wire adcr_pkg::adcr_power_t powerCtl,
    input wire logic chopEnable,
    input wire adcr_pkg::adcr_clkch_t frameClockCfg,
    input wire adcr_pkg::adcr_clkch_t bitClockCfg,
    input wire logic [3:0] bitClockPhase,
    input wire logic [9:0] bitClockPhaseDeg,
    input wire logic [7:0] rateOverride
);
    timeunit 1ns;
    timeprecision 1ps;
    import adcr_pkg::*;

    logic [3:0] gap, actCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    function automatic adcr_power_t pmMap(input logic [1:0] m);
        case (m)
            2'h1: pmMap = 3'h2;
            2'h2: pmMap = 3'h0;
            2'h3: pmMap = 3'h6;
            default: pmMap = 3'h5;
        endcase
    endfunction

    // Gap is only trusted once the divider has run a while
    always_ff @(posedge clk) begin
        if (rst || !clkDivActive) begin
            actCnt <= 4'h0;
        end else if (actCnt != 4'hf) begin
            actCnt <= actCnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || sampleStrobe) begin
            gap <= 4'h1;
        end else if (gap != 4'hf) begin
            gap <= gap + 4'h1;
        end
    end

    sequence s_wr(logic [8:0] a);
        regReq.wr && regReq.addr == a;
    endsequence

    sequence s_pm_wr;
        s_wr(POWER_MODE_CONTROL) ##0 regReq.data[1:0] != 2'h0 ##1
            !(regReq.wr && regReq.addr == POWER_MODE_CONTROL);
    endsequence

    property p_rd_valid;
        regReq.rd |=> regRdValid;
    endproperty
    property p_chop;
        s_wr(ENHANCEMENT_CONTROL) ##1
            !(regReq.wr && regReq.addr == ENHANCEMENT_CONTROL)
            |=> chopEnable == $past(regReq.data[CHOP_BIT], 2);
    endproperty
    property p_pm;
        s_pm_wr |=> ##1 powerCtl == pmMap($past(regReq.data[1:0], 3));
    endproperty
    property p_rate;
        $changed(rateOverride) |-> $past(regReq.addr) == UPDATE_STROBE
            && $past(regReq.wr) && $past(regReq.data[TRANSFER_BIT]);
    endproperty
    property p_deg;
        bitClockPhaseDeg == {6'h00, bitClockPhase} * DEG_PER_STEP;
    endproperty
    property p_strobe_rd;
        regReq.rd && regReq.addr == UPDATE_STROBE
            |=> regRdValid && regRdData == 8'h00;
    endproperty
    property p_gap;
        sampleStrobe && actCnt == 4'hf && $stable(clkDivRatio)
            |-> gap == {1'b0, clkDivRatio} + 4'h1;
    endproperty
    property p_term;
        !(frameClockCfg.term != 2'h0 && frameClockCfg.drive2x)
            && !(bitClockCfg.term != 2'h0 && bitClockCfg.drive2x);
    endproperty

    a_rd_valid: assert property (p_rd_valid)
        else $error("read not answered next cycle");
    a_chop: assert property (p_chop)
        else $error("chop enable does not follow write");
    a_pm: assert property (p_pm)
        else $error("power controls wrong for mode");
    a_rate: assert property (p_rate)
        else $error("override changed without transfer");
    a_deg: assert property (p_deg)
        else $error("bit clock degrees not code times sixty");
    a_strobe_rd: assert property (p_strobe_rd)
        else $error("transfer register did not read zero");
    a_gap: assert property (p_gap)
        else $error("sample strobe spacing wrong");
    a_term: assert property (p_term)
        else $error("double drive with termination set");
endmodule

bind adcr_config_regs adcr_config_regs_chk i_adcr_config_regs_chk (
    .clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .clkDivActive(clkDivActive),
    .clkDivRatio(clkDivRatio), .sampleStrobe(sampleStrobe),
    .powerCtl(powerCtl), .chopEnable(chopEnable),
    .frameClockCfg(frameClockCfg), .bitClockCfg(bitClockCfg),
    .bitClockPhase(bitClockPhase), .bitClockPhaseDeg(bitClockPhaseDeg),
    .rateOverride(rateOverride)
);

// *** dv/adcr_config_regs_tb.sv ***
// Self-checking bench of the configuration register bank.
// Assumes the host model in dv/ and the bound port checker.
module adcr_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcr_pkg::*;

    typedef struct packed {
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } adcr_row_t;

    // ----------------------------------------
    // Cases: write, then expected read back
    // ----------------------------------------
    localparam adcr_row_t ROWS [10] = '{
        '{9'h00c, 8'hff, 8'h04}, '{9'h00c, 8'h00, 8'h00},
        '{9'h014, 8'hff, 8'h45}, '{9'h014, 8'h01, 8'h01},
        '{9'h015, 8'hff, 8'h31}, '{9'h015, 8'h00, 8'h00},
        '{9'h016, 8'hff, 8'h0f}, '{9'h016, 8'h03, 8'h03},
        '{9'h00a, 8'hff, 8'h00}, '{9'h0ff, 8'h00, 8'h00}};
    localparam adcr_row_t RST_ROWS [8] = '{
        '{9'h004, 8'h00, 8'h0f}, '{9'h005, 8'h00, 8'h3f},
        '{9'h008, 8'h00, 8'h00}, '{9'h00c, 8'h00, 8'h00},
        '{9'h014, 8'h00, 8'h01}, '{9'h015, 8'h00, 8'h00},
        '{9'h016, 8'h00, 8'h03}, '{9'h100, 8'h00, 8'h00}};
    localparam adcr_power_t PM_EXP [4] = '{3'h5, 3'h2, 3'h0, 3'h6};

    logic clk, rst, regRdValid, power_down_pin, clkDivActive;
    logic sampleStrobe, chopEnable, reducedSwing, ok;
    adcr_req_t regReq;
    logic [7:0] regRdData, rateOverride, rdv;
    logic [2:0] clkDivRatio;
    logic [NUM_DATA_CH*SAMPLE_W-1:0] sampleIn, sampleOut;
    adcr_power_t powerCtl;
    adcr_chan_t [NUM_DATA_CH-1:0] dataChanCfg;
    adcr_clkch_t frameClockCfg, bitClockCfg;
    logic [3:0] bitClockPhase;
    logic [9:0] bitClockPhaseDeg;
    int errCount = 0, checks = 0, cnt = 0;

    adcr_config_regs i_adcr_config_regs (
        .clk(clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .power_down_pin(power_down_pin),
        .clkDivActive(clkDivActive), .clkDivRatio(clkDivRatio),
        .sampleIn(sampleIn), .sampleOut(sampleOut),
        .sampleStrobe(sampleStrobe), .powerCtl(powerCtl),
        .chopEnable(chopEnable), .reducedSwing(reducedSwing),
        .dataChanCfg(dataChanCfg), .frameClockCfg(frameClockCfg),
        .bitClockCfg(bitClockCfg), .bitClockPhase(bitClockPhase),
        .bitClockPhaseDeg(bitClockPhaseDeg), .rateOverride(rateOverride)
    );

    adcr_host i_adcr_host (
        .clk(clk), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .divRatio(clkDivRatio)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // A read that never answers ends the run
    task automatic rdChk(input logic [8:0] a, input logic [7:0] e);
        i_adcr_host.rd(a, rdv, ok);
        if (ok !== 1'b1) begin
            errCount++;
            $display("[ERR] %0t read not answered", $time);
            printVerdict();
        end else begin
            check(rdv, e);
        end
    endtask

    task automatic wrWait(input logic [8:0] a, input logic [7:0] d);
        i_adcr_host.wr(a, d);
        repeat (3) @(negedge clk);
    endtask

    initial begin
        rst = 1'b1;
        power_down_pin = 1'b0;
        clkDivActive = 1'b0;
        clkDivRatio = 3'h0;
        sampleIn = {NUM_DATA_CH{14'h0005}};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        foreach (ROWS[i]) begin
            i_adcr_host.wr(ROWS[i].a, ROWS[i].d);
            rdChk(ROWS[i].a, ROWS[i].e);
        end
        $display("test rows done");
        // Second reset in mid run
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        foreach (RST_ROWS[i]) begin
            rdChk(RST_ROWS[i].a, RST_ROWS[i].e);
        end
        check(powerCtl, 3'h5);
        check(bitClockPhaseDeg, 10'h0b4);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            wrWait(POWER_MODE_CONTROL, 8'(m));
            check(powerCtl, PM_EXP[m]);
            rdChk(CLOCK_PHASE_CONTROL, 8'h03);
        end
        i_adcr_host.digitalReset();
        repeat (3) @(negedge clk);
        check(powerCtl, 3'h5);
        wrWait(POWER_MODE_CONTROL, 8'h20);
        power_down_pin = 1'b1;
        repeat (6) @(negedge clk);
        check(powerCtl, 3'h0);
        wrWait(POWER_MODE_CONTROL, 8'h00);
        repeat (3) @(negedge clk);
        check(powerCtl, 3'h2);
        power_down_pin = 1'b0;
        repeat (6) @(negedge clk);
        check(powerCtl, 3'h5);
        $display("test power done");
        i_adcr_host.wr(CHANNEL_SELECT_LOW, 8'h01);
        i_adcr_host.wr(CHANNEL_SELECT_HIGH, 8'h00);
        wrWait(OUTPUT_MODE_CONTROL, 8'h44);
        check(sampleOut[13:0], 14'h0005 ^ 14'h2000 ^ 14'h3fff);
        check(sampleOut[27:14], 14'h0005);
        check(reducedSwing, 1'b1);
        check(dataChanCfg[1].twosComp, 1'b1);
        // Frame clock channel only
        i_adcr_host.wr(CHANNEL_SELECT_LOW, 8'h00);
        i_adcr_host.wr(CHANNEL_SELECT_HIGH, 8'h10);
        wrWait(OUTPUT_ADJUST_CONTROL, 8'h01);
        check(frameClockCfg.drive2x, 1'b1);
        check(bitClockCfg.drive2x, 1'b0);
        check(dataChanCfg[0].drive2x, 1'b0);
        wrWait(OUTPUT_ADJUST_CONTROL, 8'h21);
        check(frameClockCfg, 3'h4);
        $display("test channels done");
        wrWait(RATE_OVERRIDE, 8'h55);
        check(rateOverride, 8'h00);
        wrWait(UPDATE_STROBE, 8'h01);
        check(rateOverride, 8'h55);
        for (int c = 0; c < 10; c++) begin
            wrWait(CLOCK_PHASE_CONTROL, 8'(c));
            check(bitClockPhaseDeg, c * 60);
        end
        clkDivRatio = 3'h3;
        i_adcr_host.wr(CLOCK_PHASE_CONTROL, 8'h72);
        rdChk(CLOCK_PHASE_CONTROL, 8'h32);
        clkDivActive = 1'b1;
        repeat (20) @(negedge clk);
        repeat (16) begin
            @(negedge clk);
            cnt += (sampleStrobe === 1'b1) ? 1 : 0;
        end
        check(cnt, 4);
        clkDivActive = 1'b0;
        $display("test override and phase done");
        printVerdict();
    end
endmodule
